// [std_consts.vh]
`ifndef STD_CONSTS_VH
`define STD_CONSTS_VH

// ==========================================================
// Display geometry
`define STD_PIXELS 10'h2C7
`define STD_LAST_PIXEL 10'h2C6

// ==========================================================
// Averaging count limits
`define STD_AVG_MIN 10'h002
`define STD_AVG_MAX 10'h3E7

// ==========================================================
// Trace modes
`define STD_MODE_OVERWRITE 3'h0
`define STD_MODE_AVERAGE 3'h1
`define STD_MODE_PEAK 3'h2
`define STD_MODE_FLOOR 3'h3
`define STD_MODE_FREEZE 3'h4

// ==========================================================
// Detectors
`define STD_DET_DUAL 3'h0
`define STD_DET_MAX 3'h1
`define STD_DET_MIN 3'h2
`define STD_DET_SAMPLE 3'h3
`define STD_DET_RMS 3'h4

// ==========================================================
// Reset values
`define STD_RST_MODE 3'h0
`define STD_RST_DET 3'h0
`define STD_RST_AUTO 1'h1
`define STD_RST_LFSR 16'hACE1

// ==========================================================
// Readout sources
`define STD_SRC_TRACE1 2'h0
`define STD_SRC_TRACE2 2'h1
`define STD_SRC_MEMORY 2'h2

`endif

// [std_fifo.v]
`timescale 1ns/1ns
`default_nettype none

module std_fifo #(
  parameter W = 18,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Fill side
  input wire [W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Drain side
  output wire [W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);

  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready_o = (cnt_reg != DEPTH[AW:0]);
  assign out_valid_o = (cnt_reg != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} :
                  wr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_reg <= (rd_reg == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}} :
                  rd_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // std_fifo

`default_nettype wire

// [std_trace_detector.v]
`timescale 1ns/1ns
`default_nettype none
`include "std_consts.vh"

module std_trace_detector #(
  parameter W = 16,
  parameter CW = 16,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  // Receiver sample stream
  input wire [W-1:0] sample_i,
  input wire sample_pixel_end_i,
  input wire sample_valid_i,
  output wire sample_ready_o,
  // Shared measurement settings
  input wire [9:0] avg_count_i,
  input wire continuous_i,
  input wire single_start_i,
  input wire param_change_i,
  // Active trace settings
  input wire cfg_we_i,
  input wire [2:0] cfg_mode_i,
  input wire [2:0] cfg_det_i,
  input wire cfg_auto_i,
  input wire trace2_on_i,
  input wire trace2_off_i,
  input wire select_trace1_i,
  input wire select_trace2_i,
  // Memory trace commands
  input wire store_i,
  input wire save_i,
  // Readout
  input wire [1:0] rd_src_i,
  input wire [9:0] rd_addr_i,
  output reg [W-1:0] rd_hi_o,
  output reg [W-1:0] rd_lo_o,
  output reg rd_valid_o,
  // Status
  output wire active_trace_o,
  output wire trace2_enabled_o,
  output wire running_o,
  output reg sweep_start_o,
  output reg sweep_done_o,
  output reg single_done_o,
  output wire store_busy_o,
  output reg memory_valid_o,
  output wire [2:0] det1_o,
  output wire [2:0] det2_o
);

  // ==========================================================
  // Helper functions
  function [W-1:0] isqrt;
    input [2*W-1:0] v;
    reg [W-1:0] r;
    reg [W-1:0] t;
    integer i;
    begin
      r = {W{1'b0}};
      for (i = W - 1; i >= 0; i = i - 1) begin
        t = r | ({{(W-1){1'b0}}, 1'b1} << i);
        if ({{W{1'b0}}, t} * {{W{1'b0}}, t} <= v) begin
          r = t;
        end
      end
      isqrt = r;
    end
  endfunction

  function [W-1:0] avg_step;
    input [W-1:0] old;
    input [W-1:0] nw;
    input [9:0] k;
    reg signed [W+1:0] d;
    reg signed [W+1:0] q;
    begin
      d = $signed({2'b00, nw}) - $signed({2'b00, old});
      q = d / $signed({{(W-8){1'b0}}, k});
      avg_step = old + q[W-1:0];
    end
  endfunction

  function [W-1:0] combine;
    input [2:0] m;
    input fresh;
    input [W-1:0] old;
    input [W-1:0] nw;
    input [9:0] k;
    begin
      case (m)
        `STD_MODE_AVERAGE: combine = fresh ? nw : avg_step(old, nw, k);
        `STD_MODE_PEAK: combine = (fresh || nw > old) ? nw : old;
        `STD_MODE_FLOOR: combine = (fresh || nw < old) ? nw : old;
        `STD_MODE_FREEZE: combine = old;
        default: combine = nw;
      endcase
    end
  endfunction

  function [2:0] eff_det;
    input [2:0] m;
    input auto;
    input [2:0] man;
    begin
      if (m == `STD_MODE_PEAK) begin
        eff_det = `STD_DET_MAX;
      end else if (m == `STD_MODE_FLOOR) begin
        eff_det = `STD_DET_MIN;
      end else if (auto && m == `STD_MODE_AVERAGE) begin
        eff_det = `STD_DET_SAMPLE;
      end else if (auto) begin
        eff_det = `STD_DET_DUAL;
      end else begin
        eff_det = man;
      end
    end
  endfunction

  function [9:0] clamp_avg;
    input [9:0] n;
    begin
      if (n < `STD_AVG_MIN) begin
        clamp_avg = `STD_AVG_MIN;
      end else if (n > `STD_AVG_MAX) begin
        clamp_avg = `STD_AVG_MAX;
      end else begin
        clamp_avg = n;
      end
    end
  endfunction

  // ==========================================================
  // Sample FIFO
  wire [W:0] fifo_data;
  wire fifo_valid;
  wire fifo_pop;
  wire [W-1:0] x;
  wire pix_end;

  std_fifo #(.W(W + 1), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_data_i({sample_pixel_end_i, sample_i}),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  assign x = fifo_data[W-1:0];
  assign pix_end = fifo_data[W];

  // ==========================================================
  // State
  reg [W-1:0] th0 [0:710];
  reg [W-1:0] tl0 [0:710];
  reg [W-1:0] th1 [0:710];
  reg [W-1:0] tl1 [0:710];
  reg [W-1:0] mh [0:710];
  reg [W-1:0] ml [0:710];
  reg [2:0] mode0_reg, mode1_reg, det0_reg, det1_reg;
  reg auto0_reg, auto1_reg, fresh0_reg, fresh1_reg;
  reg [9:0] swc0_reg, swc1_reg;
  reg active_reg, t2en_reg, running_reg;
  reg [9:0] left_reg;
  reg [9:0] pix_reg;
  reg [W-1:0] acc_max_reg, acc_min_reg, acc_smp_reg;
  reg [2*W+CW-1:0] acc_sq_reg;
  reg [CW-1:0] acc_cnt_reg;
  reg [15:0] lfsr_reg;
  reg cp_busy_reg, cp_src_reg;
  reg [9:0] cp_idx_reg;

  wire [9:0] n_avg = clamp_avg(avg_count_i);
  wire [2:0] act_mode = active_reg ? mode1_reg : mode0_reg;
  wire frozen = (act_mode == `STD_MODE_FREEZE);
  assign fifo_pop = running_reg && !frozen;
  wire take = fifo_pop && fifo_valid;
  wire pix_close = take && pix_end;
  wire sweep_end = pix_close && (pix_reg == `STD_LAST_PIXEL);
  wire cfg_hit = cfg_we_i;

  // ==========================================================
  // Pixel accumulation including the current sample
  wire first = (acc_cnt_reg == {CW{1'b0}});
  wire [W-1:0] cur_max = (first || x > acc_max_reg) ? x : acc_max_reg;
  wire [W-1:0] cur_min = (first || x < acc_min_reg) ? x : acc_min_reg;
  wire [W-1:0] cur_smp = (first || lfsr_reg[0]) ? x : acc_smp_reg;
  wire [2*W-1:0] x_sq = {{W{1'b0}}, x} * {{W{1'b0}}, x};
  wire [2*W+CW-1:0] cur_sq = acc_sq_reg + {{CW{1'b0}}, x_sq};
  wire [CW-1:0] cur_cnt = acc_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
  wire [2*W+CW-1:0] mean_sq = cur_sq / {{(2*W){1'b0}}, cur_cnt};
  wire [W-1:0] cur_rms = isqrt(mean_sq[2*W-1:0]);

  wire [2:0] ed0 = eff_det(mode0_reg, auto0_reg, det0_reg);
  wire [2:0] ed1 = eff_det(mode1_reg, auto1_reg, det1_reg);
  assign det1_o = ed0;
  assign det2_o = ed1;

  reg [W-1:0] dh0, dl0, dh1, dl1;
  always @* begin
    case (ed0)
      `STD_DET_MAX: begin dh0 = cur_max; dl0 = cur_max; end
      `STD_DET_MIN: begin dh0 = cur_min; dl0 = cur_min; end
      `STD_DET_SAMPLE: begin dh0 = cur_smp; dl0 = cur_smp; end
      `STD_DET_RMS: begin dh0 = cur_rms; dl0 = cur_rms; end
      default: begin dh0 = cur_max; dl0 = cur_min; end
    endcase
    case (ed1)
      `STD_DET_MAX: begin dh1 = cur_max; dl1 = cur_max; end
      `STD_DET_MIN: begin dh1 = cur_min; dl1 = cur_min; end
      `STD_DET_SAMPLE: begin dh1 = cur_smp; dl1 = cur_smp; end
      `STD_DET_RMS: begin dh1 = cur_rms; dl1 = cur_rms; end
      default: begin dh1 = cur_max; dl1 = cur_min; end
    endcase
  end

  // divisor grows with completed sweeps up to the count
  wire [9:0] k0 = (swc0_reg + 10'h001 < n_avg) ? swc0_reg + 10'h001 : n_avg;
  wire [9:0] k1 = (swc1_reg + 10'h001 < n_avg) ? swc1_reg + 10'h001 : n_avg;

  // ==========================================================
  // Trace memories
  always @(posedge clk_sys_i) begin
    if (pix_close) begin
      th0[pix_reg] <= combine(mode0_reg, fresh0_reg, th0[pix_reg], dh0, k0);
      tl0[pix_reg] <= combine(mode0_reg, fresh0_reg, tl0[pix_reg], dl0, k0);
      // second trace uses the same samples
      if (t2en_reg) begin
        th1[pix_reg] <= combine(mode1_reg, fresh1_reg, th1[pix_reg], dh1, k1);
        tl1[pix_reg] <= combine(mode1_reg, fresh1_reg, tl1[pix_reg], dl1, k1);
      end
    end
    // snapshot copy, untouched by later settings
    if (cp_busy_reg) begin
      mh[cp_idx_reg] <= cp_src_reg ? th1[cp_idx_reg] : th0[cp_idx_reg];
      ml[cp_idx_reg] <= cp_src_reg ? tl1[cp_idx_reg] : tl0[cp_idx_reg];
    end
  end

  // ==========================================================
  // Accumulators and pixel position
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc_max_reg <= {W{1'b0}};
      acc_min_reg <= {W{1'b0}};
      acc_smp_reg <= {W{1'b0}};
      acc_sq_reg <= {(2*W+CW){1'b0}};
      acc_cnt_reg <= {CW{1'b0}};
      pix_reg <= 10'h000;
      lfsr_reg <= `STD_RST_LFSR;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      // clear on pixel close, sweep restart or abort
      if (pix_close || param_change_i || !running_reg || frozen) begin
        acc_cnt_reg <= {CW{1'b0}};
        acc_sq_reg <= {(2*W+CW){1'b0}};
      end else if (take) begin
        acc_max_reg <= cur_max;
        acc_min_reg <= cur_min;
        acc_smp_reg <= cur_smp;
        acc_sq_reg <= cur_sq;
        acc_cnt_reg <= cur_cnt;
      end
      if (param_change_i || !running_reg || frozen || sweep_end) begin
        pix_reg <= 10'h000;
      end else if (pix_close) begin
        pix_reg <= pix_reg + 10'h001;
      end
    end
  end

  // ==========================================================
  // Trace settings and sweep control
  wire start_run = !running_reg && !frozen && (continuous_i || single_start_i);

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mode0_reg <= `STD_RST_MODE;
      mode1_reg <= `STD_RST_MODE;
      det0_reg <= `STD_RST_DET;
      det1_reg <= `STD_RST_DET;
      auto0_reg <= `STD_RST_AUTO;
      auto1_reg <= `STD_RST_AUTO;
      fresh0_reg <= 1'b1;
      fresh1_reg <= 1'b1;
      swc0_reg <= 10'h000;
      swc1_reg <= 10'h000;
      active_reg <= 1'b0;
      t2en_reg <= 1'b0;
      running_reg <= 1'b0;
      left_reg <= 10'h000;
      sweep_start_o <= 1'b0;
      sweep_done_o <= 1'b0;
      single_done_o <= 1'b0;
    end else begin
      sweep_start_o <= 1'b0;
      sweep_done_o <= sweep_end;
      single_done_o <= 1'b0;
      // enabling trace 2 makes it active
      if (trace2_on_i) begin
        t2en_reg <= 1'b1;
        active_reg <= 1'b1;
        fresh1_reg <= 1'b1;
        swc1_reg <= 10'h000;
      end else if (trace2_off_i) begin
        t2en_reg <= 1'b0;
        active_reg <= 1'b0;
      end else if (select_trace1_i) begin
        active_reg <= 1'b0;
      end else if (select_trace2_i && t2en_reg) begin
        active_reg <= 1'b1;
      end
      // Sweep end ages both traces.
      if (sweep_end) begin
        fresh0_reg <= 1'b0;
        fresh1_reg <= 1'b0;
        if (swc0_reg < n_avg) begin
          swc0_reg <= swc0_reg + 10'h001;
        end
        if (swc1_reg < n_avg) begin
          swc1_reg <= swc1_reg + 10'h001;
        end
      end
      if (param_change_i) begin
        fresh0_reg <= 1'b1;
        fresh1_reg <= 1'b1;
        swc0_reg <= 10'h000;
        swc1_reg <= 10'h000;
      end
      if (cfg_hit && !active_reg) begin
        mode0_reg <= cfg_mode_i;
        det0_reg <= cfg_det_i;
        auto0_reg <= cfg_auto_i;
        if (cfg_mode_i != mode0_reg) begin
          fresh0_reg <= 1'b1;
          swc0_reg <= 10'h000;
        end
      end
      if (cfg_hit && active_reg) begin
        mode1_reg <= cfg_mode_i;
        det1_reg <= cfg_det_i;
        auto1_reg <= cfg_auto_i;
        if (cfg_mode_i != mode1_reg) begin
          fresh1_reg <= 1'b1;
          swc1_reg <= 10'h000;
        end
      end
      if (frozen) begin
        running_reg <= 1'b0;
      end else if (param_change_i && running_reg) begin
        sweep_start_o <= 1'b1;
      end else if (start_run) begin
        running_reg <= 1'b1;
        sweep_start_o <= 1'b1;
        // averaging single run takes the count
        left_reg <= (act_mode == `STD_MODE_AVERAGE) ? n_avg : 10'h001;
      end else if (sweep_end) begin
        if (continuous_i) begin
          sweep_start_o <= 1'b1;
        end else if (left_reg <= 10'h001) begin
          running_reg <= 1'b0;
          single_done_o <= 1'b1;
        end else begin
          left_reg <= left_reg - 10'h001;
          sweep_start_o <= 1'b1;
        end
      end
    end
  end

  assign active_trace_o = active_reg;
  assign trace2_enabled_o = t2en_reg;
  assign running_o = running_reg;

  // ==========================================================
  // Memory trace copy and readout
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cp_busy_reg <= 1'b0;
      cp_src_reg <= 1'b0;
      cp_idx_reg <= 10'h000;
      memory_valid_o <= 1'b0;
      rd_hi_o <= {W{1'b0}};
      rd_lo_o <= {W{1'b0}};
      rd_valid_o <= 1'b0;
    end else begin
      if (!cp_busy_reg && (store_i || save_i)) begin
        cp_busy_reg <= 1'b1;
        cp_src_reg <= active_reg;
        cp_idx_reg <= 10'h000;
      end else if (cp_busy_reg) begin
        if (cp_idx_reg == `STD_LAST_PIXEL) begin
          cp_busy_reg <= 1'b0;
          memory_valid_o <= 1'b1;
        end else begin
          cp_idx_reg <= cp_idx_reg + 10'h001;
        end
      end
      rd_valid_o <= (rd_addr_i < `STD_PIXELS);
      if (rd_addr_i < `STD_PIXELS) begin
        case (rd_src_i)
          `STD_SRC_TRACE1: begin rd_hi_o <= th0[rd_addr_i]; rd_lo_o <= tl0[rd_addr_i]; end
          `STD_SRC_TRACE2: begin rd_hi_o <= th1[rd_addr_i]; rd_lo_o <= tl1[rd_addr_i]; end
          default: begin rd_hi_o <= mh[rd_addr_i]; rd_lo_o <= ml[rd_addr_i]; end
        endcase
      end
    end
  end

  assign store_busy_o = cp_busy_reg;

endmodule // std_trace_detector

`default_nettype wire

// [std_trace_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
`include "std_consts.vh"
module std_trace_checker (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Settings and commands
  input wire logic cfg_we_i,
  input wire logic [2:0] cfg_mode_i,
  input wire logic [2:0] cfg_det_i,
  input wire logic cfg_auto_i,
  input wire logic continuous_i,
  input wire logic trace2_on_i,
  input wire logic store_i,
  input wire logic save_i,
  input wire logic [9:0] rd_addr_i,
  // Status
  input wire logic rd_valid_o,
  input wire logic active_trace_o,
  input wire logic trace2_enabled_o,
  input wire logic running_o,
  input wire logic sweep_start_o,
  input wire logic sweep_done_o,
  input wire logic single_done_o,
  input wire logic store_busy_o,
  input wire logic memory_valid_o,
  input wire logic [2:0] det1_o,
  input wire logic [2:0] det2_o
);
  logic [10:0] busy_cnt;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      busy_cnt <= 11'h000;
    end else begin
      busy_cnt <= store_busy_o ? busy_cnt + 11'h001 : 11'h000;
    end
  end
  property p_force;
    cfg_we_i && !active_trace_o && (cfg_mode_i == `STD_MODE_PEAK || cfg_mode_i == `STD_MODE_FLOOR)
    |=> det1_o == (($past(cfg_mode_i) == `STD_MODE_PEAK) ? `STD_DET_MAX : `STD_DET_MIN);
  endproperty
  property p_auto;
    cfg_we_i && cfg_auto_i && !active_trace_o && cfg_mode_i <= `STD_MODE_AVERAGE
    |=> det1_o == (($past(cfg_mode_i) == `STD_MODE_AVERAGE) ? `STD_DET_SAMPLE : `STD_DET_DUAL);
  endproperty
  property p_manual;
    cfg_we_i && !cfg_auto_i && !active_trace_o && cfg_mode_i <= `STD_MODE_AVERAGE
    |=> det1_o == $past(cfg_det_i);
  endproperty
  property p_other_trace;
    cfg_we_i && !active_trace_o |=> $stable(det2_o);
  endproperty
  property p_freeze;
    cfg_we_i && cfg_mode_i == `STD_MODE_FREEZE |=> ##[0:1] !running_o;
  endproperty
  property p_free_run;
    sweep_done_o && continuous_i && running_o |-> ##[0:2] sweep_start_o;
  endproperty
  property p_copy_take;
    (store_i || save_i) && !store_busy_o |=> store_busy_o;
  endproperty
  property p_copy_len;
    $fell(store_busy_o) |-> busy_cnt == 11'h2C7 ##[0:1] memory_valid_o;
  endproperty
  property p_rd_range;
    1'b1 |=> rd_valid_o == ($past(rd_addr_i) < `STD_PIXELS);
  endproperty
  property p_trace2_on;
    trace2_on_i |=> trace2_enabled_o && active_trace_o;
  endproperty
  property p_single_end;
    single_done_o |-> ##[0:1] !running_o;
  endproperty
  a_force: assert property (p_force) else $error("retain mode detector wrong");
  a_auto: assert property (p_auto) else $error("automatic detector wrong");
  a_manual: assert property (p_manual) else $error("manual detector lost");
  a_other_trace: assert property (p_other_trace) else $error("inactive detector moved");
  a_freeze: assert property (p_freeze) else $error("freeze kept running");
  a_free_run: assert property (p_free_run) else $error("no immediate new sweep");
  a_copy_take: assert property (p_copy_take) else $error("copy not taken");
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
  a_rd_range: assert property (p_rd_range) else $error("read valid wrong");
  a_trace2_on: assert property (p_trace2_on) else $error("second trace not active");
  a_single_end: assert property (p_single_end) else $error("single run kept going");
  c_free: cover property (sweep_done_o && continuous_i);
  c_single: cover property (single_done_o);
  c_copy: cover property ($fell(store_busy_o));
  c_trace2: cover property (trace2_enabled_o && active_trace_o);
endmodule // std_trace_checker
bind std_trace_detector std_trace_checker std_trace_checker_i (.*);
`default_nettype wire

// [std_rx_model.sv]
`timescale 1ns/1ns
`default_nettype none
module std_rx_model #(
  parameter logic [9:0] NPIX = 10'h2C7
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control
  input wire logic go_i,
  input wire logic [7:0] n_i,
  input wire logic [15:0] base_i,
  input wire logic [15:0] step_i,
  // Stream
  input wire logic ready_i,
  output wire logic [15:0] sample_o,
  output wire logic pixel_end_o,
  output var logic valid_o
);
  logic [7:0] left_reg;
  logic [9:0] pix_reg;
  logic k_reg;
  logic [15:0] cur_reg;
  logic [15:0] last_reg;
  wire [15:0] value = (k_reg ^ pix_reg[0]) ? cur_reg + 16'h0010 : cur_reg;
  // Outside a sweep the data shows the inverse of the last word, never a stale copy.
  assign sample_o = valid_o ? value : ~last_reg;
  assign pixel_end_o = valid_o & k_reg;
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      left_reg <= 8'h00;
      pix_reg <= 10'h000;
      k_reg <= 1'b0;
      cur_reg <= 16'h0000;
      last_reg <= 16'h0000;
      valid_o <= 1'b0;
    end else if (go_i) begin
      left_reg <= n_i;
      cur_reg <= base_i;
      pix_reg <= 10'h000;
      k_reg <= 1'b0;
      valid_o <= 1'b1;
    end else if (valid_o && ready_i) begin
      last_reg <= value;
      k_reg <= ~k_reg;
      if (k_reg && pix_reg == NPIX - 10'h001) begin
        pix_reg <= 10'h000;
        cur_reg <= cur_reg + step_i;
        left_reg <= left_reg - 8'h01;
        valid_o <= (left_reg != 8'h01);
      end else if (k_reg) begin
        pix_reg <= pix_reg + 10'h001;
      end
    end
  end
endmodule // std_rx_model
`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "std_consts.vh"
module testbench;
  logic clk_sys_i, reset_i, sample_pixel_end_i, sample_valid_i, sample_ready_o, continuous_i;
  logic single_start_i, param_change_i, cfg_we_i, cfg_auto_i, trace2_on_i, trace2_off_i;
  logic select_trace1_i, select_trace2_i, store_i, save_i, rd_valid_o, active_trace_o;
  logic trace2_enabled_o, running_o, sweep_start_o, sweep_done_o, single_done_o, go;
  logic store_busy_o, memory_valid_o;
  logic [15:0] sample_i, rd_hi_o, rd_lo_o, base, step;
  logic [9:0] avg_count_i, rd_addr_i;
  logic [2:0] cfg_mode_i, cfg_det_i, det1_o, det2_o;
  logic [1:0] rd_src_i;
  logic [7:0] nsw;
  int fail_count = 0, n_checks = 0, nsd = 0, cyc = 0;
  std_trace_detector std_trace_detector_i (.clk_sys_i, .reset_i, .sample_i, .sample_pixel_end_i,
    .sample_valid_i, .sample_ready_o, .avg_count_i, .continuous_i, .single_start_i,
    .param_change_i, .cfg_we_i, .cfg_mode_i, .cfg_det_i, .cfg_auto_i, .trace2_on_i,
    .trace2_off_i, .select_trace1_i, .select_trace2_i, .store_i, .save_i, .rd_src_i, .rd_addr_i,
    .rd_hi_o, .rd_lo_o, .rd_valid_o, .active_trace_o, .trace2_enabled_o, .running_o,
    .sweep_start_o, .sweep_done_o, .single_done_o, .store_busy_o, .memory_valid_o, .det1_o,
    .det2_o);
  std_rx_model std_rx_model_i (.clk_sys_i, .reset_i, .go_i(go), .n_i(nsw), .base_i(base),
    .step_i(step), .ready_i(sample_ready_o), .sample_o(sample_i),
    .pixel_end_o(sample_pixel_end_i), .valid_o(sample_valid_i));
  always #50 clk_sys_i = ~clk_sys_i;
  // ==========================================
  // Watchdog and sweep counter
  always @(posedge clk_sys_i) begin
    cyc++;
    if (sweep_done_o === 1'b1) nsd++;
    if (cyc == 60000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      close_out;
    end
  end
  // ==========================================
  // Shared tasks
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task cnt(input logic ok);
    n_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t mismatch", $time);
    end
  endtask
  task cfg(input logic [2:0] m, input logic [2:0] d, input logic a);
    cfg_mode_i = m;
    cfg_det_i = d;
    cfg_auto_i = a;
    cfg_we_i = 1'b1;
    tick(1);
    cfg_we_i = 1'b0;
    tick(1);
  endtask
  task run(input logic [7:0] n, input logic [15:0] b, input logic [15:0] s, input logic st);
    nsw = n;
    base = b;
    step = s;
    go = (n != 8'h00);
    single_start_i = st;
    tick(1);
    go = 1'b0;
    single_start_i = 1'b0;
    while (st && single_done_o !== 1'b1) tick(1);
  endtask
  task pix3(input logic [1:0] s, input logic [15:0] hi, input logic [15:0] lo);
    logic [9:0] a [3];
    a = '{10'h000, 10'h001, `STD_LAST_PIXEL};
    for (int i = 0; i < 3; i++) begin
      rd_src_i = s;
      rd_addr_i = a[i];
      tick(1);
      cnt(rd_hi_o === hi && rd_lo_o === lo && rd_valid_o === 1'b1);
    end
  endtask
  task copy(input logic sv);
    store_i = ~sv;
    save_i = sv;
    tick(1);
    store_i = 1'b0;
    save_i = 1'b0;
    cnt(store_busy_o === 1'b1);
    while (store_busy_o === 1'b1) tick(1);
  endtask
  function int isq(input int m);
    int r;
    r = 0;
    while ((r + 1) * (r + 1) <= m) r++;
    return r;
  endfunction
  // ==========================================
  // Scenarios
  task t_basic;
    logic [2:0] at [4];
    at = '{`STD_DET_DUAL, `STD_DET_SAMPLE, `STD_DET_MAX, `STD_DET_MIN};
    cnt(det1_o === `STD_DET_DUAL && running_o === 1'b0 && memory_valid_o === 1'b0);
    cnt(trace2_enabled_o === 1'b0 && active_trace_o === 1'b0);
    run(1, 16'h0100, 16'h0000, 1'b0);
    tick(24);
    cnt(sample_ready_o === 1'b0);
    run(0, 16'h0100, 16'h0000, 1'b1);
    pix3(0, 16'h0110, 16'h0100);
    rd_addr_i = 10'h2C7;
    tick(1);
    cnt(rd_valid_o === 1'b0);
    run(1, 16'h0080, 16'h0000, 1'b1);
    pix3(0, 16'h0090, 16'h0080);
    for (int i = 0; i < 4; i++) begin
      cfg(i[2:0], `STD_DET_RMS, 1'b1);
      cnt(det1_o === at[i]);
    end
    cfg(`STD_MODE_AVERAGE, `STD_DET_RMS, 1'b0);
    cnt(det1_o === `STD_DET_RMS);
    $display("basic test finished");
  endtask
  task t_dets;
    logic [2:0] d [4];
    logic [15:0] e [3];
    d = '{`STD_DET_MAX, `STD_DET_MIN, `STD_DET_RMS, `STD_DET_SAMPLE};
    e = '{16'h0110, 16'h0100, 16'(isq((32'h100 * 32'h100 + 32'h110 * 32'h110) / 2))};
    for (int i = 0; i < 4; i++) begin
      cfg(`STD_MODE_OVERWRITE, d[i], 1'b0);
      run(1, 16'h0100, 16'h0000, 1'b1);
      if (i < 3) pix3(0, e[i], e[i]);
    end
    rd_addr_i = 10'h003;
    tick(1);
    cnt((rd_hi_o === 16'h0100 || rd_hi_o === 16'h0110) && rd_lo_o === rd_hi_o);
    $display("detector test finished");
  endtask
  task t_retain;
    cfg(`STD_MODE_PEAK, `STD_DET_MAX, 1'b0);
    run(2, 16'h0100, 16'hFF80, 1'b1);
    run(0, 16'h0000, 16'h0000, 1'b1);
    pix3(0, 16'h0110, 16'h0110);
    param_change_i = 1'b1;
    tick(1);
    param_change_i = 1'b0;
    run(1, 16'h0080, 16'h0000, 1'b1);
    pix3(0, 16'h0090, 16'h0090);
    cfg(`STD_MODE_FLOOR, `STD_DET_MIN, 1'b0);
    run(2, 16'h0080, 16'h0080, 1'b1);
    run(0, 16'h0000, 16'h0000, 1'b1);
    pix3(0, 16'h0080, 16'h0080);
    $display("retain test finished");
  endtask
  task t_average;
    avg_count_i = 10'h001;
    cfg(`STD_MODE_AVERAGE, `STD_DET_MAX, 1'b0);
    nsd = 0;
    run(2, 16'h0100, 16'h0100, 1'b1);
    tick(1);
    cnt(nsd == 2 && running_o === 1'b0);
    pix3(0, 16'h0190, 16'h0190);
    avg_count_i = 10'h002;
    cfg(`STD_MODE_AVERAGE, `STD_DET_MAX, 1'b0);
    continuous_i = 1'b1;
    nsd = 0;
    run(3, 16'h0100, 16'h0100, 1'b0);
    while (nsd < 3) tick(1);
    continuous_i = 1'b0;
    cfg(`STD_MODE_FREEZE, `STD_DET_MAX, 1'b0);
    cnt(running_o === 1'b0);
    pix3(0, 16'h0260, 16'h0260);
    copy(1'b0);
    cnt(memory_valid_o === 1'b1);
    param_change_i = 1'b1;
    tick(1);
    param_change_i = 1'b0;
    pix3(2, 16'h0260, 16'h0260);
    $display("average test finished");
  endtask
  task t_trace2;
    trace2_on_i = 1'b1;
    tick(1);
    trace2_on_i = 1'b0;
    cnt(trace2_enabled_o === 1'b1 && active_trace_o === 1'b1);
    cfg(`STD_MODE_OVERWRITE, `STD_DET_MIN, 1'b0);
    cnt(det2_o === `STD_DET_MIN && det1_o === `STD_DET_MAX);
    run(1, 16'h0040, 16'h0000, 1'b1);
    pix3(1, 16'h0040, 16'h0040);
    pix3(0, 16'h0260, 16'h0260);
    copy(1'b1);
    pix3(2, 16'h0040, 16'h0040);
    select_trace1_i = 1'b1;
    tick(1);
    select_trace1_i = 1'b0;
    trace2_off_i = 1'b1;
    cnt(active_trace_o === 1'b0 && trace2_enabled_o === 1'b1);
    tick(1);
    trace2_off_i = 1'b0;
    cnt(trace2_enabled_o === 1'b0);
    $display("second trace test finished");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {clk_sys_i, sample_i, rd_src_i, rd_addr_i, cfg_mode_i, cfg_det_i, nsw, base, step} = '0;
    {continuous_i, single_start_i, param_change_i, cfg_we_i, cfg_auto_i, go} = '0;
    {trace2_on_i, trace2_off_i, select_trace1_i, select_trace2_i, store_i, save_i} = '0;
    avg_count_i = 10'h00A;
    reset_i = 1'b1;
    tick(3);
    reset_i = 1'b0;
    t_basic;
    t_dets;
    t_retain;
    t_average;
    t_trace2;
    close_out;
  end
endmodule // testbench
`default_nettype wire
